/* File: design/dmrs_params.svh */
// Constants for the DDR2 mode-register load controller.
// Notes on behaviour
// R01: Main register load: all command pins and both bank bits low; A0-A12 captured.
// R02: Every mode register must be written after power-up; contents start undefined.
// R03: Load only with all banks precharged and clock enable already high.
// R04: After each load wait the load delay before the next command.
// R05: Loads in normal operation follow the same rules while all banks idle.
// R06: Main bits A0-A2 burst length, A3 sequential or interleaved order.
// R07: Main bits A4-A6 read latency; whole clocks only.
// R08: Main A7 is test mode and written low; A8 requests loop reset.
// R09: Main A9-A11 write recovery, recovery time over clock period, rounded up.
// R10: Clock period below 1.875 ns forces the write recovery field to 000.
// R11: Burst order wraps within four words, or XORs index with start.
// R12: After the loop is enabled, wait 200 clocks before any read.
// R13: First extended load: BA1 low, BA0 high, other command pins low.
// R14: First extended A0 enables the loop, A1 selects reduced drive.
// R15: First extended A3-A5 added latency, A7-A9 calibration, A10 strobe disable.
// R16: Termination value is coded by first extended bits A2 and A6.
// R17: First extended A11 is reserved and written zero.
// R18: Adjustable calibration load carries the previous added latency unchanged.
// R19: After default calibration state, a further load writes A9-A7 as 000.
// R20: Second extended load: BA0 low, BA1 high; A7 high-temperature refresh rate.
// R21: Second extended A3 duty cycle corrector; A4-A6, A8-A12 written zero.
// R22: Second extended A0-A2 partial array refresh range; 000 when unused.
// R23: Third extended register is selected with both bank bits high.
// R24: Third extended register is written all zero apart from bank bits.
// R25: Each register keeps its contents between loads; loads touch one register.
`ifndef DMRS_PARAMS_SVH
`define DMRS_PARAMS_SVH

`define DMRS_CLK_PERIOD_NS 10
`define DMRS_LOAD_DELAY_NS 20
`define DMRS_LOAD_DELAY_CYC ((`DMRS_LOAD_DELAY_NS + `DMRS_CLK_PERIOD_NS - 1) / `DMRS_CLK_PERIOD_NS)
`define DMRS_DLL_WAIT_CYC 8'hC8
`define DMRS_TCK_WAP_MIN_PS 16'h0753
`define DMRS_WR_MIN_CYC 16'h0002
`define DMRS_WR_MAX_CYC 16'h0008

`define DMRS_OFS_CTRL 8'h00
`define DMRS_OFS_TIMING 8'h04
`define DMRS_OFS_LOAD 8'h08
`define DMRS_OFS_STATUS 8'h0C
`define DMRS_OFS_SHADOW0 8'h10
`define DMRS_OFS_SHADOW1 8'h14
`define DMRS_OFS_SHADOW2 8'h18
`define DMRS_OFS_SHADOW3 8'h1C

`define DMRS_CTRL_CKE 0
`define DMRS_CTRL_PART_REFRESH 1
`define DMRS_CTRL_RST 32'h0000_0000
`define DMRS_TIMING_RST 32'h3A98_2710
`define DMRS_LOAD_TGT_LSB 16
`define DMRS_ST_BUSY 0
`define DMRS_ST_READ_OK 1
`define DMRS_ST_WRITTEN_LSB 2
`define DMRS_ST_ERR 6

`endif

/* File: design/dmrs_pkg.sv */
// Types shared by the mode-register load controller.
package dmrs_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DIV = 4'h2,
        ST_ISSUE = 4'h4,
        ST_WAIT = 4'h8
    } dmrs_state_t;

    typedef enum logic [1:0] {
        TGT_MAIN = 2'h0,
        TGT_EXT1 = 2'h1,
        TGT_EXT2 = 2'h2,
        TGT_EXT3 = 2'h3
    } dmrs_target_t;
endpackage

/* File: design/dmrs_tmr_if.sv */
// Carrier between the controller and its command spacing timer.
`timescale 1ns/100ps
interface dmrs_tmr_if;
    logic start;
    logic [7:0] count;
    logic busy;
    modport ctrl (output start, output count, input busy);
    modport tmr (input start, input count, output busy);
endinterface

/* File: design/dmrs_delay_timer.sv */
// Down counter that spaces commands after a register load.
`timescale 1ns/100ps
module dmrs_delay_timer (
    input wire logic clk,
    input wire logic rst_n,
    dmrs_tmr_if.tmr t
);
    logic [7:0] cnt_reg;

    // Loads on start, then counts down to zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
        end else if (t.start) begin
            cnt_reg <= t.count;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // Busy while counting.
    assign t.busy = (cnt_reg != 8'h00);
endmodule

/* File: design/dmrs_ctrl.sv */
// Wishbone-driven controller that programs the DDR2 mode registers.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "dmrs_params.svh"
module dmrs_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic banks_idle,
    output logic mem_cke,
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [1:0] mem_ba,
    output logic [12:0] mem_addr,
    output logic read_ok
);
    import dmrs_pkg::*;

    dmrs_state_t state_reg;
    dmrs_pkg::dmrs_target_t tgt_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] timing_reg;
    logic [31:0] load_reg;
    logic [12:0] shadow_reg [0:3];
    logic [3:0] written_reg;
    logic err_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [15:0] rem_reg;
    logic [15:0] wrc_reg;
    logic exit_pend_reg;
    logic [12:0] pay_reg;
    logic cke_reg;
    logic cke_prev_reg;
    logic [7:0] dll_cnt_reg;
    logic dll_seen_reg;
    logic read_ok_reg;
    logic cs_n_reg;
    logic ras_n_reg;
    logic cas_n_reg;
    logic we_n_reg;
    logic [1:0] ba_reg;
    logic [12:0] addr_reg;
    logic wb_acc;
    logic wb_wr;
    logic load_wr;
    logic fast_clk;
    logic cke_held;
    logic fire;
    logic fire_dll;
    logic [12:0] pay_fix;

    dmrs_tmr_if tmr ();

    dmrs_delay_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .t(tmr.tmr)
    );

    // Merges write data into a register under the byte lane selects.
    function automatic logic [31:0] wmerge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Turns a recovery cycle count into its three-bit field, clamped.
    function automatic logic [2:0] wr_code(input logic [15:0] cyc);
        logic [15:0] c;
        c = cyc;
        if (c < `DMRS_WR_MIN_CYC) begin
            c = `DMRS_WR_MIN_CYC;
        end
        if (c > `DMRS_WR_MAX_CYC) begin
            c = `DMRS_WR_MAX_CYC;
        end
        c = c - 16'h0001;
        return c[2:0];
    endfunction

    // Forces reserved and dependent bits of a payload to legal values.
    function automatic logic [12:0] fix_payload(
        input dmrs_target_t tgt,
        input logic [12:0] a,
        input logic [2:0] add_lat,
        input logic [2:0] wr,
        input logic fast,
        input logic part_ref_en
    );
        logic [12:0] r;
        r = a;
        case (tgt)
            TGT_MAIN: begin
                r[7] = 1'b0; // see R08
                r[11:9] = fast ? 3'h0 : wr; // see R09, see R10
            end
            TGT_EXT1: begin
                r[11] = 1'b0; // see R17
                if (a[9:7] == 3'h4) begin
                    r[5:3] = add_lat; // see R18
                end
            end
            TGT_EXT2: begin
                r[6:4] = 3'h0; // see R21
                r[12:8] = 5'h00;
                if (!part_ref_en) begin
                    r[2:0] = 3'h0; // see R22
                end
            end
            default: begin
                r = 13'h0000; // see R24
            end
        endcase
        return r;
    endfunction

    // Bus decode and the derived gating terms.
    assign wb_acc = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr = wb_acc && wb_we_i;
    assign load_wr = wb_wr && (wb_adr_i == `DMRS_OFS_LOAD) && (wb_sel_i == 4'hF);
    assign fast_clk = (timing_reg[15:0] < `DMRS_TCK_WAP_MIN_PS);
    assign cke_held = cke_reg && cke_prev_reg; // see R03
    assign fire = (state_reg == ST_ISSUE) && banks_idle && cke_held; // see R03, see R05
    assign fire_dll = fire && (((tgt_reg == TGT_EXT1) && !pay_reg[0])
        || ((tgt_reg == TGT_MAIN) && pay_reg[8]));
    assign pay_fix = fix_payload(tgt_reg, pay_reg, shadow_reg[1][5:3],
        wr_code(wrc_reg), fast_clk, ctrl_reg[`DMRS_CTRL_PART_REFRESH]);

    // Single-cycle acknowledge, dropped in the following cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_acc;
        end
    end

    // Software-written control, timing and load request registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= `DMRS_CTRL_RST;
            timing_reg <= `DMRS_TIMING_RST;
            load_reg <= 32'h0000_0000;
        end else if (wb_wr) begin
            if (wb_adr_i == `DMRS_OFS_CTRL) begin
                ctrl_reg <= wmerge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_0003;
            end
            if (wb_adr_i == `DMRS_OFS_TIMING) begin
                timing_reg <= wmerge(timing_reg, wb_dat_i, wb_sel_i);
            end
            if (load_wr && (state_reg == ST_IDLE)) begin
                load_reg <= wb_dat_i & 32'h0003_1FFF;
            end
        end
    end

    // Refused load flag: set by a load while busy; write one to clear, set wins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_reg <= 1'b0;
        end else if (load_wr && (state_reg != ST_IDLE)) begin
            err_reg <= 1'b1;
        end else if (wb_wr && (wb_adr_i == `DMRS_OFS_STATUS)
            && wb_sel_i[0] && wb_dat_i[`DMRS_ST_ERR]) begin
            err_reg <= 1'b0;
        end
    end

    // Registered read data for every mapped offset; zero elsewhere.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dat_reg <= 32'h0000_0000;
        end else if (wb_acc && !wb_we_i) begin
            case (wb_adr_i)
                `DMRS_OFS_CTRL: dat_reg <= ctrl_reg;
                `DMRS_OFS_TIMING: dat_reg <= timing_reg;
                `DMRS_OFS_LOAD: dat_reg <= load_reg;
                `DMRS_OFS_STATUS: begin
                    dat_reg <= {25'h0000000, err_reg, written_reg,
                        read_ok_reg, (state_reg != ST_IDLE)};
                end
                `DMRS_OFS_SHADOW0: dat_reg <= {19'h00000, shadow_reg[0]};
                `DMRS_OFS_SHADOW1: dat_reg <= {19'h00000, shadow_reg[1]};
                `DMRS_OFS_SHADOW2: dat_reg <= {19'h00000, shadow_reg[2]};
                `DMRS_OFS_SHADOW3: dat_reg <= {19'h00000, shadow_reg[3]};
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Clock enable follows software and remembers its previous level.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cke_reg <= 1'b0;
            cke_prev_reg <= 1'b0;
        end else begin
            cke_reg <= ctrl_reg[`DMRS_CTRL_CKE];
            cke_prev_reg <= cke_reg;
        end
    end

    // Sequencer: accept, compute recovery, issue, then hold the load delay.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            tgt_reg <= TGT_MAIN;
            pay_reg <= 13'h0000;
            rem_reg <= 16'h0000;
            wrc_reg <= 16'h0000;
            exit_pend_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (load_wr) begin
                        tgt_reg <= dmrs_target_t'(wb_dat_i[`DMRS_LOAD_TGT_LSB +: 2]);
                        pay_reg <= wb_dat_i[12:0];
                        rem_reg <= timing_reg[31:16];
                        wrc_reg <= 16'h0000;
                        if ((wb_dat_i[`DMRS_LOAD_TGT_LSB +: 2] == 2'h0) && !fast_clk) begin
                            state_reg <= ST_DIV;
                        end else begin
                            state_reg <= ST_ISSUE;
                        end
                    end
                end
                ST_DIV: begin
                    // Repeated subtraction gives the rounded-up quotient.
                    if (rem_reg == 16'h0000) begin
                        state_reg <= ST_ISSUE;
                    end else begin
                        wrc_reg <= wrc_reg + 16'h0001; // see R09
                        if (rem_reg > timing_reg[15:0]) begin
                            rem_reg <= rem_reg - timing_reg[15:0];
                        end else begin
                            rem_reg <= 16'h0000;
                        end
                    end
                end
                ST_ISSUE: begin
                    if (fire) begin
                        state_reg <= ST_WAIT;
                        if ((tgt_reg == TGT_EXT1) && (pay_fix[9:7] == 3'h7)) begin
                            exit_pend_reg <= 1'b1; // see R19
                        end
                    end
                end
                ST_WAIT: begin
                    if (!tmr.busy && !tmr.start) begin // see R04
                        if (exit_pend_reg) begin
                            exit_pend_reg <= 1'b0;
                            tgt_reg <= TGT_EXT1;
                            pay_reg <= shadow_reg[1] & 13'h1C7F; // see R19
                            state_reg <= ST_ISSUE;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Start the load delay in the cycle the command is driven.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr.start <= 1'b0;
            tmr.count <= 8'h00;
        end else begin
            tmr.start <= fire;
            tmr.count <= 8'(`DMRS_LOAD_DELAY_CYC); // see R04
        end
    end

    // Mirror of each loaded register and the record of which were written.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                shadow_reg[i] <= 13'h0000;
            end
            written_reg <= 4'h0;
        end else if (fire) begin
            shadow_reg[tgt_reg] <= pay_fix; // see R25
            written_reg[tgt_reg] <= 1'b1; // see R02
        end
    end

    // Command pins: load command for one cycle, otherwise no-operation, or deselect while clock enable is low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_n_reg <= 1'b1;
            ras_n_reg <= 1'b1;
            cas_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            ba_reg <= 2'h0;
            addr_reg <= 13'h0000;
        end else if (fire) begin
            cs_n_reg <= 1'b0; // see R01, see R13, see R20, see R23
            ras_n_reg <= 1'b0;
            cas_n_reg <= 1'b0;
            we_n_reg <= 1'b0;
            ba_reg <= tgt_reg;
            addr_reg <= pay_fix;
        end else begin
            cs_n_reg <= !cke_reg;
            ras_n_reg <= 1'b1;
            cas_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            ba_reg <= 2'h0;
            addr_reg <= 13'h0000;
        end
    end

    // Loop settle counter holds reads off after an enable or reset load.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dll_cnt_reg <= 8'h00;
            dll_seen_reg <= 1'b0;
            read_ok_reg <= 1'b0;
        end else begin
            if (fire_dll) begin
                dll_cnt_reg <= `DMRS_DLL_WAIT_CYC; // see R12
                dll_seen_reg <= 1'b1;
            end else if (dll_cnt_reg != 8'h00) begin
                dll_cnt_reg <= dll_cnt_reg - 8'h01;
            end
            read_ok_reg <= dll_seen_reg && (dll_cnt_reg == 8'h00) && !fire_dll; // see R12
        end
    end

    // Outputs straight from flip-flops.
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign mem_cke = cke_reg;
    assign mem_cs_n = cs_n_reg;
    assign mem_ras_n = ras_n_reg;
    assign mem_cas_n = cas_n_reg;
    assign mem_we_n = we_n_reg;
    assign mem_ba = ba_reg;
    assign mem_addr = addr_reg;
    assign read_ok = read_ok_reg;
endmodule

/* File: tb/dmrs_dev_model.sv */
// Behavioural model of the memory's mode registers.
`timescale 1ns/100ps
module dmrs_dev_model (
    input wire logic clk,
    input wire logic idle,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    output logic [3:0][12:0] mr,
    output int loads,
    output int viol
);
    logic cke_q;
    int gap;
    // Registers start unknown, so nothing may rely on them unwritten.
    initial begin
        cke_q = 1'b0;
        gap = 9;
        loads = 0;
        viol = 0;
    end
    // Decodes a load, writes only the register that the bank bits pick.
    always @(posedge clk) begin
        cke_q <= cke;
        gap <= gap + 1;
        if (cke && !cs_n && !ras_n && !cas_n && !we_n) begin
            mr[ba] <= addr;
            loads <= loads + 1;
            gap <= 0;
            if (!cke_q || !idle || gap < 1) begin
                viol <= viol + 1;
            end
        end
    end
endmodule

/* File: tb/dmrs_ctrl_properties.sv */
// Assertions on the ports of the mode-register load controller.
`timescale 1ns/100ps
module dmrs_ctrl_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic banks_idle,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [1:0] mem_ba,
    input wire logic [12:0] mem_addr,
    input wire logic read_ok
);
    logic ld;
    logic [7:0] low_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A load command is all four command pins low.
    assign ld = !mem_cs_n && !mem_ras_n && !mem_cas_n && !mem_we_n;
    // Counts the cycles that the read-ready flag has been low.
    always_ff @(posedge clk) begin
        if (!rst_n || read_ok) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_load_cke_held: assert property (ld |-> mem_cke && $past(mem_cke) && $past(mem_cke, 2))
        else $error("load without clock enable held");
    a_load_banks_idle: assert property (ld |-> $past(banks_idle))
        else $error("load while banks busy");
    a_load_gap_nop: assert property (ld |=> (!mem_cs_n && mem_ras_n && mem_cas_n && mem_we_n) [*2])
        else $error("no load delay after load");
    a_main_test_low: assert property (ld && mem_ba == 2'h0 |-> !mem_addr[7])
        else $error("test mode bit set");
    a_ext1_rsvd_zero: assert property (ld && mem_ba == 2'h1 |-> !mem_addr[11])
        else $error("reserved bit set in first extended");
    a_ext2_rsvd_zero: assert property (ld && mem_ba == 2'h2 |-> mem_addr[6:4] == 3'h0
        && mem_addr[12:8] == 5'h00)
        else $error("reserved bits set in second extended");
    a_ext3_all_zero: assert property (ld && mem_ba == 2'h3 |-> mem_addr == 13'h0000)
        else $error("third extended not zero");
    a_settle_wait: assert property ($rose(read_ok) |-> low_cnt >= 8'hC3)
        else $error("read ready too early");
endmodule
bind dmrs_ctrl dmrs_ctrl_properties u_dmrs_ctrl_properties (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .banks_idle(banks_idle),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr), .read_ok(read_ok));

/* File: tb/tb.sv */
// Self-checking bench for the mode-register load controller.
`timescale 1ns/100ps
`include "dmrs_params.svh"
module tb;
    import dmrs_pkg::*;
    logic clk, rst_n, cyc, stb, we, ack, idle, cke, cs_n, ras_n, cas_n, we_n, rok;
    logic [7:0] adr;
    logic [3:0] sel, wm;
    logic [31:0] dw, rdat, rd;
    logic [1:0] ba;
    logic [12:0] ma;
    logic [3:0][12:0] mr, em;
    int loads, viol, miscompares, checks, n, l0;
    // Each row: clock period, write recovery, payload, expected main value.
    localparam logic [63:0] MT [4] = '{64'h2710_3A98_1FFF_137F, 64'h0752_3A98_0E32_0032,
        64'h0753_3A98_0000_0E00, 64'h09C4_7530_0043_0E43};
    dmrs_ctrl u_dmrs_ctrl (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(rdat),
        .wb_ack_o(ack), .banks_idle(idle), .mem_cke(cke), .mem_cs_n(cs_n), .mem_ras_n(ras_n),
        .mem_cas_n(cas_n), .mem_we_n(we_n), .mem_ba(ba), .mem_addr(ma), .read_ok(rok));
    dmrs_dev_model u_dmrs_dev_model (.clk(clk), .idle(idle), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(ma), .mr(mr),
        .loads(loads), .viol(viol));
    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict;
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        print_verdict();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic cycle, held until ack is seen at a rising edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        sel <= s;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) hang();
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(nm, e, rd);
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            bus(1'b0, `DMRS_OFS_STATUS, 32'h0000_0000, 4'hF);
            k++;
        end while (rd[`DMRS_ST_BUSY] !== 1'b0 && k < 100);
        if (k >= 100) hang();
    endtask
    task automatic issue(input dmrs_target_t t, input logic [12:0] p);
        bus(1'b1, `DMRS_OFS_LOAD, {14'h0000, t, 3'h0, p}, 4'hF);
    endtask
    // Waits for the load and compares every written register with its expectation.
    task automatic done(input dmrs_target_t t, input logic [12:0] e);
        int i;
        wait_idle();
        em[t] = e;
        wm[t] = 1'b1;
        for (i = 0; i < 4; i++) begin
            if (wm[i]) chk("mode register", 32'(em[i]), 32'(mr[i]));
        end
    endtask
    task automatic load(input dmrs_target_t t, input logic [12:0] p, input logic [12:0] e);
        issue(t, p);
        done(t, e);
    endtask
    task automatic t_reset;
        rdc("ctrl", `DMRS_OFS_CTRL, `DMRS_CTRL_RST);
        rdc("timing", `DMRS_OFS_TIMING, `DMRS_TIMING_RST);
        bus(1'b1, `DMRS_OFS_TIMING, 32'hFFFF_FF55, 4'h1);
        rdc("timing lanes", `DMRS_OFS_TIMING, 32'h3A98_2755);
        bus(1'b1, `DMRS_OFS_TIMING, `DMRS_TIMING_RST, 4'hF);
        rdc("status", `DMRS_OFS_STATUS, 32'h0000_0000);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
        rdc("unmapped", 8'h40, 32'h0000_0000);
    endtask
    task automatic t_cke_and_ext;
        issue(TGT_EXT2, 13'h1FFF);
        repeat (20) @(posedge clk);
        chk("loads", 0, loads);
        bus(1'b1, `DMRS_OFS_CTRL, 32'h0000_0001, 4'hF);
        done(TGT_EXT2, 13'h0088);
        load(TGT_EXT3, 13'h1FFF, 13'h0000);
        bus(1'b1, `DMRS_OFS_CTRL, 32'h0000_0003, 4'hF);
        load(TGT_EXT2, 13'h0005, 13'h0005);
        bus(1'b1, `DMRS_OFS_CTRL, 32'h0000_0001, 4'hF);
    endtask
    task automatic t_ext1;
        load(TGT_EXT1, 13'h086E, 13'h006E);
        chk("read_ok low", 0, 32'(rok));
        n = 0;
        while (rok !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("settle", 1, 32'(n >= 180 && n <= 201));
    endtask
    task automatic t_main;
        int i;
        for (i = 0; i < 4; i++) begin
            bus(1'b1, `DMRS_OFS_TIMING, {MT[i][47:32], MT[i][63:48]}, 4'hF);
            load(TGT_MAIN, MT[i][28:16], MT[i][12:0]);
        end
        rdc("shadow main", `DMRS_OFS_SHADOW0, 32'h0000_0E43);
        bus(1'b1, `DMRS_OFS_TIMING, `DMRS_TIMING_RST, 4'hF);
    endtask
    task automatic t_calib;
        load(TGT_EXT1, 13'h0200, 13'h0228);
        l0 = loads;
        load(TGT_EXT1, 13'h0382, 13'h0002);
        chk("exit load", l0 + 2, loads);
    endtask
    task automatic t_busy_banks;
        idle <= 1'b0;
        l0 = loads;
        issue(TGT_EXT3, 13'h0000);
        repeat (20) @(posedge clk);
        chk("held load", l0, loads);
        issue(TGT_EXT2, 13'h0000);
        bus(1'b1, `DMRS_OFS_LOAD, 32'h0002_0000, 4'h3);
        idle <= 1'b1;
        done(TGT_EXT3, 13'h0000);
        chk("one load", l0 + 1, loads);
        chk("refused", 1, 32'(rd[`DMRS_ST_ERR]));
        bus(1'b1, `DMRS_OFS_STATUS, 32'h0000_0040, 4'hF);
        rdc("cleared", `DMRS_OFS_STATUS, 32'h0000_003C);
        chk("device order", 0, viol);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dw = 32'h0000_0000;
        idle = 1'b1;
        wm = 4'h0;
        miscompares = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_cke_and_ext();
        t_ext1();
        t_main();
        t_calib();
        t_busy_banks();
        print_verdict();
    end
endmodule
